/* File: fscp_status_protect.sv */
// Status, lock and array protection logic of the serial flash
// What this block does
// [R1] Granule bit picks 4KB sectors or 64KB blocks
// [R2] Invert bit swaps protected and writable regions
// [R3] Factory image holds invert bit at zero
// [R4] Two lock mode bits at S8, S7
// [R5] Mode 00: guard pin ignored, needs latch
// [R6] Mode 01, guard low: refuse status writes
// [R7] Mode 01, guard high: needs write latch
// [R8] Mode 10 locks until power cycle, then 00
// [R9] Mode 11 refuses status writes forever
// [R10] Suspend instruction sets the paused flag
// [R11] Resume or power cycle clears paused flag
// [R12] Security locks set individually, never cleared
// [R13] Quad enable disables guard and pause pins
// [R14] Four-wire mode entry needs quad enable
// [R15] Four-wire mode keeps quad enable set
// [R16] Scheme bit picks range or individual locks
// [R17] Individual locks all set after reset
// [R18] Drive strength code, default 25 percent
// [R19] Pause-or-reset select, only without quad
// [R20] Reserved bits read zero, writes ignored
// [R21] Block ranges protect top or bottom fraction
// [R22] Sector ranges protect 4KB to 32KB
// [R23] Range code 111 protects whole array
// [R24] Range bits at status S4 to S2
// [R25] Refuse erase or program touching protection
// [R26] Protection uses latest completed status writes
`timescale 1ns/100ps

module fscp_status_protect
  import fscp_pkg::*;
#(
  parameter int SECT_W = 12
) (
  // Core clock and power-cycle reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  // Link clock side, decoded instructions
  input  wire logic                sck_i,
  input  wire logic                lnk_reset_i,
  input  wire logic                cmd_valid_i,
  input  wire fscp_pkg::fscp_cmd_s cmd_i,
  output logic                     cmd_ready_o,
  // Write guard pin, active low
  input  wire logic                guard_n_i,
  // Non-volatile image in and out
  input  wire fscp_pkg::fscp_nv_s  nv_image_i,
  output fscp_pkg::fscp_nv_s       nv_image_o,
  // Status and results
  output logic [7:0]               stat1_o,
  output logic [7:0]               stat2_o,
  output logic [7:0]               stat3_o,
  output fscp_pkg::fscp_rsp_s      rsp_o,
  output logic                     four_wire_mode_o,
  output logic [1:0]               drive_strength_o,
  output logic                     guard_fn_o,
  output logic                     pause_fn_o,
  output logic                     reset_fn_o
);
  import fscp_pkg::*;
  localparam int NSECT = 1 << SECT_W;
  localparam int NBLK  = NSECT / FSCP_SECTS_PER_BLK;
  localparam int NEDGE = 2 * FSCP_SECTS_PER_BLK;

  // Below 1024 sectors the 1/64 range step loses a whole block
  if (SECT_W < 10 || SECT_W > 12) begin : g_bad_sect_w
    $error("SECT_W must lie between 10 and 12");
  end

  typedef struct packed {
    fscp_nv_s         nv;
    logic             paused_flag;
    logic             write_latch_flag;
    logic             four_wire_command_mode;
    logic [NBLK-1:0]  blk_lock;
    logic [NEDGE-1:0] edge_lock;
    logic             grd_s1;
    logic             grd_s2;
    logic             req_s1;
    logic             req_s2;
    logic             req_s3;
    logic             ack_tgl;
    fscp_rsp_s        rsp;
  } fscp_core_s;

  typedef struct packed {
    fscp_cmd_s cmd;
    logic      req_tgl;
    logic      ack_s1;
    logic      ack_s2;
  } fscp_lnk_s;

  fscp_core_s core_ff;
  fscp_core_s nxt_core;
  fscp_lnk_s  lnk_ff;
  fscp_lnk_s  nxt_lnk;

  // Link domain: hold the command until the core acknowledges it
  assign cmd_ready_o = (lnk_ff.req_tgl == lnk_ff.ack_s2);

  always_comb begin
    nxt_lnk        = lnk_ff;
    nxt_lnk.ack_s1 = core_ff.ack_tgl;
    nxt_lnk.ack_s2 = lnk_ff.ack_s1;
    if (cmd_valid_i && cmd_ready_o) begin
      nxt_lnk.cmd     = cmd_i;
      nxt_lnk.req_tgl = ~lnk_ff.req_tgl;
    end
    if (lnk_reset_i) begin
      nxt_lnk = '0;
    end
  end

  always_ff @(posedge sck_i) begin
    lnk_ff <= nxt_lnk;
  end

  // Any sector of [lo, hi] protected by the current scheme
  function automatic logic prot_hit(input fscp_core_s st, input int lo, input int hi);
    logic       hit;
    logic [2:0] code;
    int         size;
    int         plo;
    int         phi;
    int         blo;
    int         sidx;
    hit  = 1'b0;
    code = {st.nv.range_code_hi, st.nv.range_code_mid, st.nv.range_code_lo};
    size = 0;
    plo  = 0;
    phi  = -1;
    // [R16] scheme selection
    if (st.nv.lock_scheme_select) begin
      for (int b = 1; b < NBLK - 1; b++) begin
        blo = b * FSCP_SECTS_PER_BLK;
        if (st.blk_lock[b] && blo <= hi && blo + FSCP_SECTS_PER_BLK - 1 >= lo) begin
          hit = 1'b1;
        end
      end
      for (int s = 0; s < NEDGE; s++) begin
        sidx = (s < FSCP_SECTS_PER_BLK) ? s : NSECT - NEDGE + s;
        if (st.edge_lock[s] && sidx >= lo && sidx <= hi) begin
          hit = 1'b1;
        end
      end
    end else begin
      // [R23] whole array
      if (code == FSCP_RANGE_ALL) begin
        size = NSECT;
      end else if (code == FSCP_RANGE_NONE) begin
        size = 0;
      // [R22] sector granule sizes
      end else if (st.nv.granule_select) begin
        size = 1 << ((int'(code) - 1 > FSCP_FINE_MAX_LOG) ? FSCP_FINE_MAX_LOG : int'(code) - 1);
      // [R21] block fractions
      end else begin
        size = NSECT >> (FSCP_RANGE_TOP - int'(code));
      end
      // [R1] side and granule place the region
      if (size != 0) begin
        plo = st.nv.side_select ? 0 : NSECT - size;
        phi = plo + size - 1;
      end
      // [R2] inverted map: only the selected region is writable
      if (st.nv.invert_protection) begin
        hit = !(size != 0 && lo >= plo && hi <= phi);
      end else begin
        hit = (size != 0) && lo <= phi && hi >= plo;
      end
    end
    return hit;
  endfunction

  // Core domain
  always_comb begin
    logic [1:0]        mode;
    logic              wr_ok;
    logic [SECT_W-1:0] sidx;
    int                rlo;
    int                rsz;
    fscp_cmd_s         cmd;
    nxt_core     = core_ff;
    mode         = {core_ff.nv.status_lock_mode_hi, core_ff.nv.status_lock_mode_lo};
    cmd          = lnk_ff.cmd;
    sidx         = cmd.addr[SECT_W+FSCP_SECT_SHIFT-1:FSCP_SECT_SHIFT];
    rlo          = 0;
    rsz          = 0;
    wr_ok        = 1'b0;
    nxt_core.rsp = '0;
    nxt_core.grd_s1 = guard_n_i;
    nxt_core.grd_s2 = core_ff.grd_s1;
    nxt_core.req_s1 = lnk_ff.req_tgl;
    nxt_core.req_s2 = core_ff.req_s1;
    nxt_core.req_s3 = core_ff.req_s2;
    case (mode)
      // [R5] software lock mode
      FSCP_LOCK_SOFT: wr_ok = core_ff.write_latch_flag;
      // [R6] [R7] guard pin mode, [R13] pin inert under quad
      FSCP_LOCK_PIN:  wr_ok = core_ff.write_latch_flag && (core_ff.nv.quad_io_enable || core_ff.grd_s2);
      // [R8] [R9] supply lock-down and permanent lock
      default:        wr_ok = 1'b0;
    endcase
    // [R26] each command sees all earlier completed writes
    if (core_ff.req_s3 != core_ff.req_s2) begin
      nxt_core.ack_tgl  = ~core_ff.ack_tgl;
      nxt_core.rsp.done = 1'b1;
      case (cmd.opcode)
        FSCP_OP_WR_ENABLE: begin
          nxt_core.write_latch_flag = 1'b1;
          nxt_core.rsp.accepted     = 1'b1;
        end
        FSCP_OP_WR_DISABLE: begin
          nxt_core.write_latch_flag = 1'b0;
          nxt_core.rsp.accepted     = 1'b1;
        end
        FSCP_OP_WR_STAT1: begin
          nxt_core.write_latch_flag = 1'b0;
          nxt_core.rsp.accepted     = wr_ok;
          // [R24] range bits from S4..S2
          if (wr_ok) begin
            nxt_core.nv.status_lock_mode_lo = cmd.data[FSCP_S1_LOCK_LO];
            nxt_core.nv.granule_select      = cmd.data[FSCP_S1_GRANULE];
            nxt_core.nv.side_select         = cmd.data[FSCP_S1_SIDE];
            nxt_core.nv.range_code_hi       = cmd.data[FSCP_S1_RANGE+2];
            nxt_core.nv.range_code_mid      = cmd.data[FSCP_S1_RANGE+1];
            nxt_core.nv.range_code_lo       = cmd.data[FSCP_S1_RANGE];
          end
        end
        FSCP_OP_WR_STAT2: begin
          nxt_core.write_latch_flag = 1'b0;
          nxt_core.rsp.accepted     = wr_ok;
          if (wr_ok) begin
            // [R4] lock mode high bit at S8
            nxt_core.nv.status_lock_mode_hi = cmd.data[FSCP_S2_LOCK_HI];
            nxt_core.nv.invert_protection   = cmd.data[FSCP_S2_INVERT];
            // [R12] one-time locks only accumulate
            nxt_core.nv.otp_lock_three = core_ff.nv.otp_lock_three | cmd.data[FSCP_S2_OTP+2];
            nxt_core.nv.otp_lock_two   = core_ff.nv.otp_lock_two | cmd.data[FSCP_S2_OTP+1];
            nxt_core.nv.otp_lock_one   = core_ff.nv.otp_lock_one | cmd.data[FSCP_S2_OTP];
            // [R15] no quad clear in four-wire mode
            nxt_core.nv.quad_io_enable = cmd.data[FSCP_S2_QUAD] |
                                         (core_ff.four_wire_command_mode & core_ff.nv.quad_io_enable);
          end
        end
        FSCP_OP_WR_STAT3: begin
          nxt_core.write_latch_flag = 1'b0;
          nxt_core.rsp.accepted     = wr_ok;
          // [R18] drive code, [R19] pause or reset select
          if (wr_ok) begin
            nxt_core.nv.pause_reset_select = cmd.data[FSCP_S3_PAUSE_RST];
            nxt_core.nv.drive_strength_hi  = cmd.data[FSCP_S3_DRIVE+1];
            nxt_core.nv.drive_strength_lo  = cmd.data[FSCP_S3_DRIVE];
            nxt_core.nv.lock_scheme_select = cmd.data[FSCP_S3_SCHEME];
          end
        end
        // [R10] suspend sets paused flag
        FSCP_OP_SUSPEND: begin
          nxt_core.paused_flag  = 1'b1;
          nxt_core.rsp.accepted = 1'b1;
        end
        // [R11] resume clears it
        FSCP_OP_RESUME: begin
          nxt_core.paused_flag  = 1'b0;
          nxt_core.rsp.accepted = 1'b1;
        end
        // [R14] entry ignored without quad enable
        FSCP_OP_ENTER_4W: begin
          nxt_core.four_wire_command_mode = core_ff.nv.quad_io_enable | core_ff.four_wire_command_mode;
          nxt_core.rsp.accepted           = core_ff.nv.quad_io_enable;
        end
        FSCP_OP_EXIT_4W: begin
          nxt_core.four_wire_command_mode = 1'b0;
          nxt_core.rsp.accepted           = 1'b1;
        end
        FSCP_OP_SECT_ERASE, FSCP_OP_PAGE_PROG, FSCP_OP_QUAD_PROG,
        FSCP_OP_HBLK_ERASE, FSCP_OP_BLK_ERASE, FSCP_OP_CHIP_ERASE, FSCP_OP_CHIP_ERASE_B: begin
          case (cmd.opcode)
            FSCP_OP_HBLK_ERASE:                        rsz = FSCP_HBLK_SECTS;
            FSCP_OP_BLK_ERASE:                         rsz = FSCP_SECTS_PER_BLK;
            FSCP_OP_CHIP_ERASE, FSCP_OP_CHIP_ERASE_B:  rsz = NSECT;
            default:                                   rsz = 1;
          endcase
          rlo = int'(sidx) & ~(rsz - 1);
          nxt_core.write_latch_flag = 1'b0;
          // [R25] refuse if any protected sector is touched
          nxt_core.rsp.accepted = core_ff.write_latch_flag && !prot_hit(core_ff, rlo, rlo + rsz - 1);
        end
        FSCP_OP_UNIT_LOCK, FSCP_OP_UNIT_UNLOCK: begin
          nxt_core.write_latch_flag = 1'b0;
          nxt_core.rsp.accepted     = core_ff.write_latch_flag;
          if (core_ff.write_latch_flag) begin
            if (sidx[SECT_W-1:FSCP_BLK_SHIFT] == '0) begin
              nxt_core.edge_lock[sidx[FSCP_BLK_SHIFT-1:0]] = (cmd.opcode == FSCP_OP_UNIT_LOCK);
            end else if (sidx[SECT_W-1:FSCP_BLK_SHIFT] == '1) begin
              nxt_core.edge_lock[{1'b1, sidx[FSCP_BLK_SHIFT-1:0]}] = (cmd.opcode == FSCP_OP_UNIT_LOCK);
            end else begin
              nxt_core.blk_lock[sidx[SECT_W-1:FSCP_BLK_SHIFT]] = (cmd.opcode == FSCP_OP_UNIT_LOCK);
            end
          end
        end
        FSCP_OP_GLOBAL_LOCK, FSCP_OP_GLOBAL_UNLOCK: begin
          nxt_core.write_latch_flag = 1'b0;
          nxt_core.rsp.accepted     = core_ff.write_latch_flag;
          if (core_ff.write_latch_flag) begin
            nxt_core.blk_lock  = {NBLK{cmd.opcode == FSCP_OP_GLOBAL_LOCK}};
            nxt_core.edge_lock = {NEDGE{cmd.opcode == FSCP_OP_GLOBAL_LOCK}};
          end
        end
        default: begin
          nxt_core.rsp.accepted = 1'b0;
        end
      endcase
    end
    // Power cycle: volatile state cleared, stored image reloaded
    if (reset_i) begin
      nxt_core    = '0;
      nxt_core.nv = nv_image_i;
      // [R8] supply lock-down released by power cycle
      if ({nv_image_i.status_lock_mode_hi, nv_image_i.status_lock_mode_lo} == FSCP_LOCK_SUPPLY) begin
        nxt_core.nv.status_lock_mode_hi = 1'b0;
        nxt_core.nv.status_lock_mode_lo = 1'b0;
      end
      // [R17] individual locks all set
      nxt_core.blk_lock  = '1;
      nxt_core.edge_lock = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    core_ff <= nxt_core;
  end

  // [R20] reserved bits read as zero
  always_comb begin
    stat1_o = '0;
    stat1_o[FSCP_S1_LOCK_LO] = core_ff.nv.status_lock_mode_lo;
    stat1_o[FSCP_S1_GRANULE] = core_ff.nv.granule_select;
    stat1_o[FSCP_S1_SIDE]    = core_ff.nv.side_select;
    stat1_o[FSCP_S1_RANGE+2] = core_ff.nv.range_code_hi;
    stat1_o[FSCP_S1_RANGE+1] = core_ff.nv.range_code_mid;
    stat1_o[FSCP_S1_RANGE]   = core_ff.nv.range_code_lo;
    stat1_o[FSCP_S1_WLATCH]  = core_ff.write_latch_flag;
    stat2_o = '0;
    stat2_o[FSCP_S2_PAUSED]  = core_ff.paused_flag;
    stat2_o[FSCP_S2_INVERT]  = core_ff.nv.invert_protection;
    stat2_o[FSCP_S2_OTP+2]   = core_ff.nv.otp_lock_three;
    stat2_o[FSCP_S2_OTP+1]   = core_ff.nv.otp_lock_two;
    stat2_o[FSCP_S2_OTP]     = core_ff.nv.otp_lock_one;
    stat2_o[FSCP_S2_QUAD]    = core_ff.nv.quad_io_enable;
    stat2_o[FSCP_S2_LOCK_HI] = core_ff.nv.status_lock_mode_hi;
    stat3_o = '0;
    stat3_o[FSCP_S3_PAUSE_RST] = core_ff.nv.pause_reset_select;
    stat3_o[FSCP_S3_DRIVE+1]   = core_ff.nv.drive_strength_hi;
    stat3_o[FSCP_S3_DRIVE]     = core_ff.nv.drive_strength_lo;
    stat3_o[FSCP_S3_SCHEME]    = core_ff.nv.lock_scheme_select;
  end

  assign nv_image_o       = core_ff.nv;
  assign rsp_o            = core_ff.rsp;
  assign four_wire_mode_o = core_ff.four_wire_command_mode;
  // [R18] drive code to pad strength
  assign drive_strength_o = {core_ff.nv.drive_strength_hi, core_ff.nv.drive_strength_lo};
  // [R13] pin roles follow quad enable
  assign guard_fn_o       = ~core_ff.nv.quad_io_enable;
  // [R19] shared pin role
  assign pause_fn_o       = ~core_ff.nv.quad_io_enable & ~core_ff.nv.pause_reset_select;
  assign reset_fn_o       = ~core_ff.nv.quad_io_enable & core_ff.nv.pause_reset_select;

endmodule // fscp_status_protect

/* File: fscp_pkg.sv */
// Shared types and constants for the flash status and protection block
package fscp_pkg;

  // Instruction codes
  localparam logic [7:0] FSCP_OP_WR_ENABLE     = 8'h06;
  localparam logic [7:0] FSCP_OP_WR_DISABLE    = 8'h04;
  localparam logic [7:0] FSCP_OP_WR_STAT1      = 8'h01;
  localparam logic [7:0] FSCP_OP_WR_STAT2      = 8'h31;
  localparam logic [7:0] FSCP_OP_WR_STAT3      = 8'h11;
  localparam logic [7:0] FSCP_OP_SUSPEND       = 8'h75;
  localparam logic [7:0] FSCP_OP_RESUME        = 8'h7A;
  localparam logic [7:0] FSCP_OP_ENTER_4W      = 8'h38;
  localparam logic [7:0] FSCP_OP_EXIT_4W       = 8'hFF;
  localparam logic [7:0] FSCP_OP_SECT_ERASE    = 8'h20;
  localparam logic [7:0] FSCP_OP_HBLK_ERASE    = 8'h52;
  localparam logic [7:0] FSCP_OP_BLK_ERASE     = 8'hD8;
  localparam logic [7:0] FSCP_OP_CHIP_ERASE    = 8'hC7;
  localparam logic [7:0] FSCP_OP_CHIP_ERASE_B  = 8'h60;
  localparam logic [7:0] FSCP_OP_PAGE_PROG     = 8'h02;
  localparam logic [7:0] FSCP_OP_QUAD_PROG     = 8'h32;
  localparam logic [7:0] FSCP_OP_UNIT_LOCK     = 8'h36;
  localparam logic [7:0] FSCP_OP_UNIT_UNLOCK   = 8'h39;
  localparam logic [7:0] FSCP_OP_GLOBAL_LOCK   = 8'h7E;
  localparam logic [7:0] FSCP_OP_GLOBAL_UNLOCK = 8'h98;

  // Bit positions in status byte one
  localparam int FSCP_S1_LOCK_LO = 7;
  localparam int FSCP_S1_GRANULE = 6;
  localparam int FSCP_S1_SIDE    = 5;
  localparam int FSCP_S1_RANGE   = 2;
  localparam int FSCP_S1_WLATCH  = 1;
  // Bit positions in status byte two
  localparam int FSCP_S2_PAUSED  = 7;
  localparam int FSCP_S2_INVERT  = 6;
  localparam int FSCP_S2_OTP     = 3;
  localparam int FSCP_S2_QUAD    = 1;
  localparam int FSCP_S2_LOCK_HI = 0;
  // Bit positions in status byte three
  localparam int FSCP_S3_PAUSE_RST = 7;
  localparam int FSCP_S3_DRIVE     = 5;
  localparam int FSCP_S3_SCHEME    = 2;

  // Array geometry, in 4KB sectors
  localparam int FSCP_SECT_SHIFT    = 12;
  localparam int FSCP_SECTS_PER_BLK = 16;
  localparam int FSCP_BLK_SHIFT     = 4;
  localparam int FSCP_HBLK_SECTS    = 8;
  localparam int FSCP_RANGE_TOP     = 7;
  localparam int FSCP_FINE_MAX_LOG  = 3;

  // Range codes with fixed meaning
  localparam logic [2:0] FSCP_RANGE_NONE = 3'h0;
  localparam logic [2:0] FSCP_RANGE_ALL  = 3'h7;

  // Lock mode encodings
  localparam logic [1:0] FSCP_LOCK_SOFT  = 2'h0;
  localparam logic [1:0] FSCP_LOCK_PIN   = 2'h1;
  localparam logic [1:0] FSCP_LOCK_SUPPLY = 2'h2;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  data;
    logic [23:0] addr;
  } fscp_cmd_s;

  typedef struct packed {
    logic done;
    logic accepted;
  } fscp_rsp_s;

  typedef struct packed {
    logic       invert_protection;
    logic       granule_select;
    logic       side_select;
    logic       range_code_hi;
    logic       range_code_mid;
    logic       range_code_lo;
    logic       status_lock_mode_hi;
    logic       status_lock_mode_lo;
    logic       quad_io_enable;
    logic       otp_lock_three;
    logic       otp_lock_two;
    logic       otp_lock_one;
    logic       lock_scheme_select;
    logic       drive_strength_hi;
    logic       drive_strength_lo;
    logic       pause_reset_select;
  } fscp_nv_s;

  // [R3] factory image keeps invert clear
  localparam fscp_nv_s FSCP_NV_FACTORY = 16'h0006;

endpackage : fscp_pkg

/* File: fscp_status_protect_props.sv */
// Port-level checks for the flash status and protection block
`timescale 1ns/100ps
module fscp_status_protect_props
  import fscp_pkg::*;
(
  // Core clock and reset
  input wire logic                clk_i,
  input wire logic                reset_i,
  // Watched outputs
  input wire fscp_pkg::fscp_nv_s  nv_image_o,
  input wire logic [7:0]          stat1_o,
  input wire logic [7:0]          stat2_o,
  input wire logic [7:0]          stat3_o,
  input wire fscp_pkg::fscp_rsp_s rsp_o,
  input wire logic                four_wire_mode_o,
  input wire logic [1:0]          drive_strength_o,
  input wire logic                guard_fn_o,
  input wire logic                pause_fn_o,
  input wire logic                reset_fn_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  drive_map_a:
    assert property (drive_strength_o == {nv_image_o.drive_strength_hi, nv_image_o.drive_strength_lo}
      && stat3_o[6:5] == drive_strength_o) else $error("drive code mismatch");
  pin_role_a:
    assert property (guard_fn_o == !nv_image_o.quad_io_enable) else $error("guard role wrong");
  pause_role_a:
    assert property ({pause_fn_o, reset_fn_o} == (nv_image_o.quad_io_enable ? 2'b00 :
      {!nv_image_o.pause_reset_select, nv_image_o.pause_reset_select})) else $error("pause role wrong");
  otp_sticky_a:
    assert property (!$fell(stat2_o[3]) && !$fell(stat2_o[4]) && !$fell(stat2_o[5]))
      else $error("security lock cleared");
  lock_freeze_a:
    assert property (nv_image_o.status_lock_mode_hi |=> $stable(nv_image_o)) else $error("locked image changed");
  pause_cause_a:
    assert property ($rose(stat2_o[7]) |-> rsp_o.done && rsp_o.accepted) else $error("pause without command");
  quad_keep_a:
    assert property (four_wire_mode_o |-> nv_image_o.quad_io_enable) else $error("quad lost in four-wire");
  quad_entry_a:
    assert property ($rose(four_wire_mode_o) |-> rsp_o.done && $past(nv_image_o.quad_io_enable))
      else $error("four-wire entry without quad");
  field_map_a:
    assert property (stat1_o[4:2] == {nv_image_o.range_code_hi, nv_image_o.range_code_mid,
      nv_image_o.range_code_lo} && stat2_o[6] == nv_image_o.invert_protection
      && stat1_o[7] == nv_image_o.status_lock_mode_lo && stat2_o[0] == nv_image_o.status_lock_mode_hi)
      else $error("status field misplaced");
  reserved_zero_a:
    assert property ((stat2_o & 8'h04) == 8'h00 && (stat3_o & 8'h1B) == 8'h00) else $error("reserved bit set");
endmodule // fscp_status_protect_props

bind fscp_status_protect fscp_status_protect_props chk_u (.clk_i, .reset_i, .nv_image_o, .stat1_o,
  .stat2_o, .stat3_o, .rsp_o, .four_wire_mode_o, .drive_strength_o, .guard_fn_o, .pause_fn_o, .reset_fn_o);

/* File: fscp_host_model.sv */
// Host controller model driving decoded commands over the link
`timescale 1ns/100ps
module fscp_host_model
  import fscp_pkg::*;
(
  // Link outputs
  output logic                sck_o,
  output logic                lnk_reset_o,
  output logic                cmd_valid_o,
  output fscp_pkg::fscp_cmd_s cmd_o,
  // Handshake from the block
  input  wire logic           cmd_ready_i
);
  initial begin
    sck_o = 1'b0;
    lnk_reset_o = 1'b1;
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // Link clock stands still between frames
  task automatic pulse();
    #40 sck_o = 1'b1;
    #40 sck_o = 1'b0;
  endtask
  task automatic link_reset();
    lnk_reset_o <= 1'b1;
    repeat (2) pulse();
    lnk_reset_o <= 1'b0;
  endtask
  task automatic send(input fscp_cmd_s c);
    logic taken;
    taken = 1'b0;
    // Odd offset keeps the link out of phase with the core
    #1.3;
    cmd_o <= c;
    cmd_valid_o <= 1'b1;
    for (int n = 0; n < 8 && !taken; n++) begin
      #40 taken = cmd_ready_i;
      sck_o = 1'b1;
      if (taken) begin
        cmd_valid_o <= 1'b0;
        cmd_o <= ~c;
      end
      #40 sck_o = 1'b0;
    end
    // Ready needs a few more edges to return
    repeat (4) pulse();
  endtask
endmodule // fscp_host_model

/* File: fscp_status_protect_tb.sv */
// Self-checking bench for the flash status and protection block
`timescale 1ns/100ps
module fscp_status_protect_tb;
  import fscp_pkg::*;
  logic       clk_i, reset_i, guard_n_i, sck_i, lnk_reset_i, cmd_valid_i, cmd_ready_o;
  fscp_nv_s   nv_image_i, nv_image_o;
  fscp_cmd_s  cmd_i;
  fscp_rsp_s  rsp_o;
  logic [7:0] stat1_o, stat2_o, stat3_o;
  logic [1:0] drive_strength_o;
  logic       four_wire_mode_o, guard_fn_o, pause_fn_o, reset_fn_o, acc;
  int         failures = 0;
  int         checks = 0;

  fscp_status_protect dut_u (.clk_i, .reset_i, .sck_i, .lnk_reset_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
    .guard_n_i, .nv_image_i, .nv_image_o, .stat1_o, .stat2_o, .stat3_o, .rsp_o, .four_wire_mode_o,
    .drive_strength_o, .guard_fn_o, .pause_fn_o, .reset_fn_o);
  fscp_host_model host_u (.sck_o(sck_i), .lnk_reset_o(lnk_reset_i), .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i), .cmd_ready_i(cmd_ready_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Storage keeps the image across power cycles
  always @(posedge clk_i) if (!reset_i) nv_image_i <= nv_image_o;
  always @(negedge clk_i) if (rsp_o.done === 1'b1) acc = rsp_o.accepted;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] dat, input logic [23:0] adr);
    acc = 1'bx;
    host_u.send({op, dat, adr});
    @(posedge clk_i);
  endtask
  task automatic wsr(input logic [7:0] op, input logic [7:0] dat);
    run(8'h06, 8'h00, 24'h0);
    run(op, dat, 24'h0);
  endtask
  task automatic erase(input logic [23:0] adr);
    run(8'h06, 8'h00, 24'h0);
    run(8'h20, 8'h00, adr);
  endtask
  task automatic power_cycle();
    reset_i <= 1'b1;
    fork
      host_u.link_reset();
      repeat (3) @(posedge clk_i);
    join
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_defaults();
    check(stat2_o, 8'h00);
    check(stat3_o, 8'h60);
    check({5'h00, guard_fn_o, pause_fn_o, reset_fn_o}, 8'h06);
  endtask
  task automatic t_soft();
    run(8'h01, 8'h04, 24'h0);
    check({7'h00, acc}, 8'h00);
    run(8'h06, 8'h00, 24'h0);
    run(8'h04, 8'h00, 24'h0);
    run(8'h01, 8'h04, 24'h0);
    check({7'h00, acc}, 8'h00);
    wsr(8'h01, 8'h04);
    check({7'h00, acc}, 8'h01);
    check(stat1_o, 8'h04);
  endtask
  task automatic t_sizes();
    run(8'h06, 8'h00, 24'h0);
    run(8'h52, 8'h00, 24'hFB8000);
    check({7'h00, acc}, 8'h01);
    run(8'h06, 8'h00, 24'h0);
    run(8'hD8, 8'h00, 24'hFC0000);
    check({7'h00, acc}, 8'h00);
    run(8'h06, 8'h00, 24'h0);
    run(8'h32, 8'h00, 24'hFBF000);
    check({7'h00, acc}, 8'h01);
    run(8'h06, 8'h00, 24'h0);
    run(8'hC7, 8'h00, 24'h0);
    check({7'h00, acc}, 8'h00);
  endtask
  task automatic t_map();
    logic [47:0] tbl [16] = '{48'h04_00_FC0000_00, 48'h04_00_FBF000_01, 48'h24_00_03F000_00,
      48'h24_00_040000_01, 48'h18_00_800000_00, 48'h18_00_7FF000_01, 48'h44_00_FFF000_00,
      48'h44_00_FFE000_01, 48'h54_00_FF8000_00, 48'h54_00_FF7000_01, 48'h64_00_000000_00,
      48'h64_00_001000_01, 48'h7C_00_000000_00, 48'h00_00_FFF000_01, 48'h44_40_FFF000_01,
      48'h44_40_000000_00};
    foreach (tbl[i]) begin
      wsr(8'h31, tbl[i][39:32]);
      wsr(8'h01, tbl[i][47:40]);
      check(stat1_o, tbl[i][47:40]);
      erase(tbl[i][31:8]);
      check({7'h00, acc}, tbl[i][7:0]);
    end
  endtask
  task automatic t_scheme();
    wsr(8'h11, 8'h64);
    erase(24'h0);
    check({7'h00, acc}, 8'h00);
    run(8'h06, 8'h00, 24'h0);
    run(8'h98, 8'h00, 24'h0);
    erase(24'h0);
    check({7'h00, acc}, 8'h01);
    run(8'h06, 8'h00, 24'h0);
    run(8'h36, 8'h00, 24'h0);
    erase(24'h0);
    check({7'h00, acc}, 8'h00);
    run(8'h06, 8'h00, 24'h0);
    run(8'h39, 8'h00, 24'h0);
    erase(24'h0);
    check({7'h00, acc}, 8'h01);
    run(8'h06, 8'h00, 24'h0);
    run(8'h7E, 8'h00, 24'h0);
    erase(24'h100000);
    check({7'h00, acc}, 8'h00);
  endtask
  task automatic t_drive();
    for (int c = 0; c < 4; c++) begin
      wsr(8'h11, {1'b0, 2'(c), 5'h00});
      check({6'h00, drive_strength_o}, 8'(c));
    end
  endtask
  task automatic t_quad();
    run(8'h38, 8'h00, 24'h0);
    check({7'h00, acc}, 8'h00);
    wsr(8'h31, 8'h02);
    check({5'h00, guard_fn_o, pause_fn_o, reset_fn_o}, 8'h00);
    run(8'h38, 8'h00, 24'h0);
    check({6'h00, acc, four_wire_mode_o}, 8'h03);
    wsr(8'h31, 8'h00);
    check(stat2_o, 8'h02);
    run(8'hFF, 8'h00, 24'h0);
    wsr(8'h31, 8'h00);
    wsr(8'h11, 8'hE0);
    check({5'h00, guard_fn_o, pause_fn_o, reset_fn_o}, 8'h05);
  endtask
  task automatic t_pause();
    run(8'h75, 8'h00, 24'h0);
    check(stat2_o, 8'h80);
    run(8'h7A, 8'h00, 24'h0);
    check(stat2_o, 8'h00);
    run(8'h75, 8'h00, 24'h0);
    power_cycle();
    check(stat2_o, 8'h00);
  endtask
  task automatic t_otp();
    wsr(8'h31, 8'h08);
    check(stat2_o, 8'h08);
    wsr(8'h31, 8'h00);
    check(stat2_o, 8'h08);
    wsr(8'h31, 8'h20);
    check(stat2_o, 8'h28);
  endtask
  task automatic t_lock();
    wsr(8'h01, 8'h80);
    guard_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wsr(8'h01, 8'h84);
    check({7'h00, acc}, 8'h00);
    guard_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wsr(8'h01, 8'h84);
    check(stat1_o, 8'h84);
    wsr(8'h01, 8'h00);
    wsr(8'h31, 8'h01);
    wsr(8'h01, 8'h04);
    check({7'h00, acc}, 8'h00);
    power_cycle();
    check(stat1_o, 8'h00);
    check({7'h00, stat2_o[0]}, 8'h00);
    wsr(8'h01, 8'h80);
    wsr(8'h31, 8'h01);
    power_cycle();
    wsr(8'h01, 8'h04);
    check({acc, stat1_o[6:0]}, 8'h00);
  endtask

  initial begin
    #150000;
    failures++;
    report_and_stop();
  end
  initial begin
    reset_i = 1'b1;
    guard_n_i = 1'b1;
    nv_image_i = FSCP_NV_FACTORY;
    @(posedge clk_i);
    power_cycle();
    t_defaults();
    t_soft();
    t_sizes();
    t_map();
    t_scheme();
    t_drive();
    t_quad();
    t_pause();
    t_otp();
    t_lock();
    report_and_stop();
  end
endmodule // fscp_status_protect_tb
